// File: dim_params.svh
// Constants for the DDR2 init and mode-register link
`ifndef DIM_PARAMS_SVH
`define DIM_PARAMS_SVH
`define DIM_CLK_NS         100
`define DIM_PWR_WAIT_NS    200000
`define DIM_PWR_WAIT_CYC   ((`DIM_PWR_WAIT_NS + `DIM_CLK_NS - 1) / `DIM_CLK_NS)
`define DIM_CKE_WAIT_NS    400
`define DIM_CKE_WAIT_CYC   ((`DIM_CKE_WAIT_NS + `DIM_CLK_NS - 1) / `DIM_CLK_NS)
`define DIM_DLL_LOCK_CYC   200
`define DIM_GAP_CYC        4
`define DIM_REFRESH_CNT    2
`define DIM_BANK_MR        3'h0
`define DIM_BANK_EMR1      3'h1
`define DIM_BANK_EMR2      3'h2
`define DIM_BANK_EMR3      3'h3
`define DIM_A_DLL_RESET    8
`define DIM_A_AUTO_PRE     10
`define DIM_A_DLL_DISABLE  0
`define DIM_OCD_LSB        7
`define DIM_OCD_MSB        9
`define DIM_OCD_DEFAULT    3'h7
`define DIM_OCD_EXIT       3'h0
`define DIM_TEST_MODE_BIT  7
`define DIM_ODT_A2         2
`define DIM_ODT_A6         6
`define DIM_ADDR_CTRL      2'h0
`define DIM_ADDR_MR        2'h1
`define DIM_ADDR_EMR1      2'h2
`define DIM_ADDR_STAT      2'h3
`define DIM_CTRL_START     0
`define DIM_CTRL_SELFREF   1
`define DIM_PWR_CNT_W      12
`define DIM_CTRL_ODT       2
`define DIM_CTRL_ACCESS    3
`define DIM_CTRL_BANK_LSB  4
`define DIM_CTRL_BANK_MSB  6
`define DIM_CTRL_AP        7
`define DIM_CTRL_ADDR_LSB  8
`define DIM_CTRL_ADDR_MSB  15
`endif

// File: dim_pkg.sv
// Types shared by both ends of the init link
package dim_pkg;
    // Command code {ras_n, cas_n, we_n}
    typedef enum logic [2:0] {
        DIM_CMD_MRS  = 3'h0,
        DIM_CMD_REF  = 3'h1,
        DIM_CMD_PRE  = 3'h2,
        DIM_CMD_ACT  = 3'h3,
        DIM_CMD_WR   = 3'h4,
        DIM_CMD_RD   = 3'h5,
        DIM_CMD_NOP  = 3'h7
    } dim_cmd_t;
endpackage

// File: dim_link_if.sv
// Command pins between controller and DRAM
interface dim_link_if;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] addr;
    logic        odt;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
    modport dram (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

// File: dim_dram.sv
// DRAM end: command decode, mode registers, DLL state
`include "dim_params.svh"
module dim_dram (
    // Link
    dim_link_if.dram     lnk,
    input  wire logic    mclk,
    input  wire logic    srst,
    // Observed state
    output logic [13:0]  mode_reg,
    output logic [13:0]  emr1_reg,
    output logic         mode_valid_reg,
    output logic         dll_on_reg,
    output logic         dll_locked_reg,
    output logic         self_ref_reg,
    output logic         odt_active_reg,
    output logic [2:0]   act_bank_reg,
    output logic [13:0]  act_row_reg,
    output logic [13:0]  col_reg,
    output logic         auto_pre_reg
);
    logic [7:0] lock_reg;
    wire [2:0] cmd = {lnk.ras_n, lnk.cas_n, lnk.we_n};
    wire       sel = lnk.cke && !lnk.cs_n;
    wire       mrs = sel && cmd == dim_pkg::DIM_CMD_MRS;
    wire       wr_mr   = mrs && lnk.ba == `DIM_BANK_MR;
    wire       wr_emr1 = mrs && lnk.ba == `DIM_BANK_EMR1;
    wire       is_act  = sel && cmd == dim_pkg::DIM_CMD_ACT;
    wire       is_rw   = sel && (cmd == dim_pkg::DIM_CMD_RD || cmd == dim_pkg::DIM_CMD_WR);
    // Self refresh: refresh command with cke falling
    wire       sr_in  = !lnk.cs_n && cmd == dim_pkg::DIM_CMD_REF && !lnk.cke && !self_ref_reg;
    wire       sr_out = self_ref_reg && lnk.cke;
    wire       dll_rst = wr_mr && lnk.addr[`DIM_A_DLL_RESET];
    wire       odt_en = emr1_reg[`DIM_ODT_A2] | emr1_reg[`DIM_ODT_A6];
    always_ff @(posedge mclk) begin
        if (srst) begin
            // No array here: mode writes cannot disturb data
            mode_reg <= 14'h0000;
            emr1_reg <= 14'h0000;
            mode_valid_reg <= 1'b0;
            dll_on_reg <= 1'b0;
            dll_locked_reg <= 1'b0;
            lock_reg <= 8'h00;
            self_ref_reg <= 1'b0;
            odt_active_reg <= 1'b0;
            act_bank_reg <= 3'h0;
            act_row_reg <= 14'h0000;
            col_reg <= 14'h0000;
            auto_pre_reg <= 1'b0;
        end else begin
            if (wr_mr) begin
                mode_reg <= lnk.addr;
                mode_valid_reg <= 1'b1;
            end
            if (wr_emr1) begin
                emr1_reg <= lnk.addr;
                dll_on_reg <= !lnk.addr[`DIM_A_DLL_DISABLE];
            end
            if (sr_in) begin
                self_ref_reg <= 1'b1;
                dll_on_reg <= 1'b0;
            end else if (sr_out) begin
                self_ref_reg <= 1'b0;
                dll_on_reg <= !emr1_reg[`DIM_A_DLL_DISABLE];
            end
            // Lock restarts on every DLL reset or re-enable, and is lost at once on self refresh entry
            if (dll_rst || sr_in || sr_out || (wr_emr1 && !lnk.addr[`DIM_A_DLL_DISABLE] && !dll_on_reg)) begin
                lock_reg <= 8'h00;
                dll_locked_reg <= 1'b0;
            end else if (!dll_on_reg) begin
                dll_locked_reg <= 1'b0;
            end else if (lock_reg < 8'(`DIM_DLL_LOCK_CYC)) begin
                lock_reg <= lock_reg + 8'h01;
            end else begin
                dll_locked_reg <= 1'b1;
            end
            odt_active_reg <= lnk.odt && odt_en && !self_ref_reg;
            if (is_act) begin
                act_bank_reg <= lnk.ba;
                act_row_reg <= lnk.addr;
            end
            if (is_rw) begin
                col_reg <= lnk.addr;
                auto_pre_reg <= lnk.addr[`DIM_A_AUTO_PRE];
            end
        end
    end
endmodule // dim_dram

// File: dim_ctrl.sv
// Controller end: power-up and mode programming sequencer
// Contract
// - Activate gives row, read/write gives column
// - Hold cke and odt low at power
// - Wait 200us, then NOP and raise cke
// - NOP 400ns, then precharge all
// - Program extended registers two then three
// - Enable DLL, then mode set resetting DLL
// - Precharge, two refreshes, final mode set
// - Calibration default then exit after 200 clocks
// - Every write carries all register fields
// - Mode writes leave array untouched
// - Mode register undefined until written
// - Mode set decode: all low, banks zero
// - Mode writes only precharged, cke high
// - Burst length, order, CAS latency fields
// - Test mode low, DLL reset, recovery
// - Recovery field is time over period, ceiling
// - Extended one decode: bank0 high, bank1 low
// - Extended one field layout
// - Self refresh disables and re-enables DLL
// - 200 clocks after DLL reset before reads
// - DLL enabled for normal operation
// - Termination pin ignored when disabled
// - Commands taken only with chip select low
`include "dim_params.svh"
module dim_ctrl #(
    parameter int PWR_WAIT_CYC = `DIM_PWR_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Register port
    input  wire logic [1:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Link
    dim_link_if.ctrl         lnk
);
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0, ST_PWR  = 4'h1, ST_CKE  = 4'h2, ST_PRE1 = 4'h3,
        ST_EMR2  = 4'h4, ST_EMR3 = 4'h5, ST_DLLE = 4'h6, ST_DLLR = 4'h7,
        ST_PRE2  = 4'h8, ST_REF  = 4'h9, ST_MR   = 4'hA, ST_OCDD = 4'hB,
        ST_OCDX  = 4'hC, ST_DONE = 4'hD, ST_SRIN = 4'hE, ST_SR   = 4'hF
    } dim_ctrl_state_t;

    dim_ctrl_state_t state_reg, state_next;
    logic [`DIM_PWR_CNT_W-1:0] wait_reg;
    logic [7:0]  lock_reg;
    logic [1:0]  ref_reg;
    logic [13:0] mr_cfg_reg, emr_cfg_reg;
    logic        start_reg, sr_req_reg;
    logic [1:0]  acc_reg;
    logic [2:0]  acc_bank_reg;
    logic [7:0]  acc_addr_reg;
    logic        acc_ap_reg, odt_req_reg;
    logic        issue;
    logic [2:0]  cmd;
    logic [2:0]  ba;
    logic [13:0] addr;

    wire gap_done  = wait_reg == '0;
    wire lock_done = lock_reg >= 8'(`DIM_DLL_LOCK_CYC);
    // Full register images each time, never a subset
    wire [13:0] emr_dll = emr_cfg_reg & ~(14'h0001 << `DIM_A_DLL_DISABLE);
    wire [13:0] emr_ocd = {emr_dll[13:10], `DIM_OCD_DEFAULT, emr_dll[6:0]};
    wire [13:0] emr_exit = {emr_dll[13:10], `DIM_OCD_EXIT, emr_dll[6:0]};
    wire [13:0] mr_norm = mr_cfg_reg & ~(14'h0001 << `DIM_A_DLL_RESET)
                          & ~(14'h0001 << `DIM_TEST_MODE_BIT);
    // Test access: one activate, then one read; only after lock
    wire [13:0] acc_row = 14'(acc_addr_reg);
    wire [13:0] acc_col = 14'(acc_addr_reg) | (14'(acc_ap_reg) << `DIM_A_AUTO_PRE);
    wire        acc_act = acc_reg == 2'h1;
    wire        acc_rd  = acc_reg == 2'h2 && lock_done;
    wire        acc_go  = state_reg == ST_DONE && gap_done;

    always_comb begin
        state_next = state_reg;
        issue = 1'b0;
        cmd = dim_pkg::DIM_CMD_NOP;
        ba = 3'h0;
        addr = 14'h0000;
        if (gap_done) begin
            unique case (state_reg)
                ST_IDLE: if (start_reg) state_next = ST_PWR;
                ST_PWR:  state_next = ST_CKE;
                ST_CKE:  state_next = ST_PRE1;
                ST_PRE1: begin
                    cmd = dim_pkg::DIM_CMD_PRE; addr = 14'h0001 << `DIM_A_AUTO_PRE;
                    issue = 1'b1; state_next = ST_EMR2;
                end
                ST_EMR2: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_EMR2;
                    issue = 1'b1; state_next = ST_EMR3;
                end
                ST_EMR3: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_EMR3;
                    issue = 1'b1; state_next = ST_DLLE;
                end
                ST_DLLE: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_EMR1; addr = emr_dll;
                    issue = 1'b1; state_next = ST_DLLR;
                end
                ST_DLLR: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_MR;
                    addr = mr_norm | (14'h0001 << `DIM_A_DLL_RESET);
                    issue = 1'b1; state_next = ST_PRE2;
                end
                ST_PRE2: begin
                    cmd = dim_pkg::DIM_CMD_PRE; addr = 14'h0001 << `DIM_A_AUTO_PRE;
                    issue = 1'b1; state_next = ST_REF;
                end
                ST_REF: begin
                    cmd = dim_pkg::DIM_CMD_REF; issue = 1'b1;
                    if (ref_reg == 2'(`DIM_REFRESH_CNT - 1)) state_next = ST_MR;
                end
                ST_MR: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_MR; addr = mr_norm;
                    issue = 1'b1; state_next = ST_OCDD;
                end
                ST_OCDD: if (lock_done) begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_EMR1; addr = emr_ocd;
                    issue = 1'b1; state_next = ST_OCDX;
                end
                ST_OCDX: begin
                    cmd = dim_pkg::DIM_CMD_MRS; ba = `DIM_BANK_EMR1; addr = emr_exit;
                    issue = 1'b1; state_next = ST_DONE;
                end
                // Access first, so no refresh or reinit lands between an activate and its read
                ST_DONE: if (acc_act) begin
                    cmd = dim_pkg::DIM_CMD_ACT;
                    ba = acc_bank_reg;
                    addr = acc_row;
                    issue = 1'b1;
                end else if (acc_rd) begin
                    cmd = dim_pkg::DIM_CMD_RD;
                    ba = acc_bank_reg;
                    addr = acc_col;
                    issue = 1'b1;
                end else if (sr_req_reg) begin
                    cmd = dim_pkg::DIM_CMD_REF; issue = 1'b1; state_next = ST_SRIN;
                end else if (start_reg) state_next = ST_PRE2;                     // reinit
                ST_SRIN: state_next = ST_SR;
                ST_SR:   if (!sr_req_reg) state_next = ST_OCDD;
            endcase
        end
    end

    // Register port
    wire [15:0] rd_mux = (reg_addr == `DIM_ADDR_MR)   ? {2'h0, mr_cfg_reg} :
                         (reg_addr == `DIM_ADDR_EMR1) ? {2'h0, emr_cfg_reg} :
                         (reg_addr == `DIM_ADDR_STAT) ? {10'h000, lock_done, state_reg == ST_DONE, state_reg} :
                         {14'h0000, sr_req_reg, start_reg};

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            wait_reg <= '0;
            lock_reg <= 8'h00;
            ref_reg <= 2'h0;
            mr_cfg_reg <= 14'h0000;
            emr_cfg_reg <= 14'h0000;
            start_reg <= 1'b0;
            sr_req_reg <= 1'b0;
            acc_reg <= 2'h0;
            acc_bank_reg <= 3'h0;
            acc_addr_reg <= 8'h00;
            acc_ap_reg <= 1'b0;
            odt_req_reg <= 1'b0;
            reg_rdata <= 16'h0000;
            lnk.cke <= 1'b0;
            lnk.odt <= 1'b0;
            lnk.cs_n <= 1'b1;
            lnk.ras_n <= 1'b1;
            lnk.cas_n <= 1'b1;
            lnk.we_n <= 1'b1;
            lnk.ba <= 3'h0;
            lnk.addr <= 14'h0000;
        end else begin
            state_reg <= state_next;
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
            if (reg_wr && reg_addr == `DIM_ADDR_MR) mr_cfg_reg <= reg_wdata[13:0];
            if (reg_wr && reg_addr == `DIM_ADDR_EMR1) emr_cfg_reg <= reg_wdata[13:0];
            if (reg_wr && reg_addr == `DIM_ADDR_CTRL) sr_req_reg <= reg_wdata[`DIM_CTRL_SELFREF];
            if (reg_wr && reg_addr == `DIM_ADDR_CTRL) odt_req_reg <= reg_wdata[`DIM_CTRL_ODT];
            // A new access is refused while one is still under way
            if (reg_wr && reg_addr == `DIM_ADDR_CTRL && reg_wdata[`DIM_CTRL_ACCESS] && acc_reg == 2'h0) begin
                acc_reg <= 2'h1;
                acc_bank_reg <= reg_wdata[`DIM_CTRL_BANK_MSB:`DIM_CTRL_BANK_LSB];
                acc_ap_reg <= reg_wdata[`DIM_CTRL_AP];
                acc_addr_reg <= reg_wdata[`DIM_CTRL_ADDR_MSB:`DIM_CTRL_ADDR_LSB];
            end else if (acc_go && acc_act) begin
                acc_reg <= 2'h2;
            end else if (acc_go && acc_rd) begin
                acc_reg <= 2'h0;
            end
            if (reg_wr && reg_addr == `DIM_ADDR_CTRL && reg_wdata[`DIM_CTRL_START]) start_reg <= 1'b1;
            else if (state_reg != state_next && state_next != ST_IDLE) start_reg <= 1'b0;
            // Gap timers; long wait only on entry to power hold
            if (state_reg == ST_IDLE && state_next == ST_PWR)
                wait_reg <= `DIM_PWR_CNT_W'(PWR_WAIT_CYC);
            else if (state_reg == ST_PWR && gap_done)
                wait_reg <= `DIM_PWR_CNT_W'(`DIM_CKE_WAIT_CYC);
            else if (issue)
                wait_reg <= `DIM_PWR_CNT_W'(`DIM_GAP_CYC);
            else if (!gap_done)
                wait_reg <= wait_reg - 1'b1;
            if (state_reg == ST_DLLR && issue) lock_reg <= 8'h00;
            else if (state_reg == ST_SR && state_next == ST_OCDD) lock_reg <= 8'h00;
            else if (!lock_done) lock_reg <= lock_reg + 8'h01;
            if (state_reg == ST_REF && issue) ref_reg <= ref_reg + 2'h1;
            else if (state_reg != ST_REF) ref_reg <= 2'h0;
            if (state_reg == ST_PWR && gap_done) lnk.cke <= 1'b1;
            else if (state_reg == ST_DONE && state_next == ST_SRIN) lnk.cke <= 1'b0;
            else if (state_reg == ST_SR && state_next == ST_OCDD) lnk.cke <= 1'b1;
            // Termination only once the sequence is done
            lnk.odt <= odt_req_reg && state_reg == ST_DONE;
            lnk.cs_n <= !issue;
            lnk.ras_n <= cmd[2];
            lnk.cas_n <= cmd[1];
            lnk.we_n <= cmd[0];
            lnk.ba <= ba;
            lnk.addr <= addr;
        end
    end
endmodule // dim_ctrl

// File: dim_link_properties.sv
// Checker for the command pins between controller and DRAM ends
module dim_link_props #(
    parameter int PWR_WAIT = 2000
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        cke,
    input  wire logic        cs_n,
    input  wire logic        ras_n,
    input  wire logic        cas_n,
    input  wire logic        we_n,
    input  wire logic [2:0]  ba,
    input  wire logic [13:0] addr,
    input  wire logic        odt
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    wire [2:0] code   = {ras_n, cas_n, we_n};
    wire       cmd_v  = cke && !cs_n && (code != dim_pkg::DIM_CMD_NOP);
    wire       is_mrs = cmd_v && (code == dim_pkg::DIM_CMD_MRS);
    wire       is_pra = cmd_v && (code == dim_pkg::DIM_CMD_PRE) && addr[10];
    wire       is_ref = cmd_v && (code == dim_pkg::DIM_CMD_REF);
    logic [15:0] up_cnt;
    logic [3:0]  idx;
    logic [9:0]  dll_cnt;
    always_ff @(posedge mclk) begin
        if (srst) up_cnt <= 16'h0000;
        else if (up_cnt != 16'hFFFF) up_cnt <= up_cnt + 16'h0001;
    end
    // Index of init command; saturates so later traffic is ignored
    always_ff @(posedge mclk) begin
        if (srst) idx <= 4'h0;
        else if (cmd_v && idx != 4'hF) idx <= idx + 4'h1;
    end
    always_ff @(posedge mclk) begin
        if (srst) dll_cnt <= 10'h000;
        else if (is_mrs && ba == 3'h0 && addr[8]) dll_cnt <= 10'h001;
        else if (dll_cnt != 10'h000 && dll_cnt != 10'h3FF) dll_cnt <= dll_cnt + 10'h001;
    end
    // Slack of one cycle for where the wait count starts
    pwr_wait_a: assert property ($rose(cke) |-> up_cnt >= PWR_WAIT - 1)
        else $error("clock enable raised too early");
    odt_low_a: assert property (!cke && idx == 4'h0 |-> !odt)
        else $error("termination pin high before clock enable");
    cke_quiet_a: assert property ($rose(cke) && idx == 4'h0 |-> !cmd_v [*4])
        else $error("command inside the quiet period");
    first_pra_a: assert property (cmd_v && idx == 4'h0 |-> is_pra)
        else $error("first command is not precharge all");
    emr23_a: assert property (cmd_v && (idx == 4'h1 || idx == 4'h2) |-> is_mrs && ba == (idx == 4'h1 ? 3'h2 : 3'h3))
        else $error("extended registers two and three out of order");
    dll_enable_a: assert property (cmd_v && idx == 4'h3 |-> is_mrs && ba == 3'h1 && !addr[0])
        else $error("DLL enable write missing");
    dll_reset_a: assert property (cmd_v && idx == 4'h4 |-> is_mrs && ba == 3'h0 && addr[8])
        else $error("DLL reset write missing");
    refresh_seq_a: assert property (cmd_v && idx inside {4'h5, 4'h6, 4'h7} |-> (idx == 4'h5 ? is_pra : is_ref))
        else $error("precharge and refresh order wrong");
    final_mr_a: assert property (cmd_v && idx == 4'h8 |-> is_mrs && ba == 3'h0 && !addr[8] && !addr[7])
        else $error("final mode write wrong");
    ocd_default_a: assert property (cmd_v && idx == 4'h9 |-> is_mrs && ba == 3'h1 && addr[9:7] == 3'h7 && dll_cnt >= 200)
        else $error("calibration default wrong or early");
    ocd_exit_a: assert property (cmd_v && idx == 4'hA |-> is_mrs && ba == 3'h1 && addr[9:7] == 3'h0 && !addr[0])
        else $error("calibration exit wrong");
    cmd_gap_a: assert property (cmd_v |=> !cmd_v [*4])
        else $error("commands closer than the gap");
    cover property (is_pra && idx == 4'h5);
    cover property (is_mrs && idx == 4'hA);
    cover property ($fell(cke) && idx > 4'hA);
    cover property (cmd_v && code == dim_pkg::DIM_CMD_RD);
endmodule // dim_link_props

// File: test_ddr2_init_mode_register.sv
// Bench joining controller and DRAM ends over the link
module test_ddr2_init_mode_register;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int          PWR    = 10;
    localparam logic [13:0] MR_A   = 14'h0242;
    localparam logic [13:0] MR_B   = 14'h0453;
    localparam logic [13:0] EMR1_A = 14'h0404;
    localparam logic [13:0] EMR1_B = 14'h0400;
    localparam logic [2:0]  ACC_BANK = 3'h5;
    localparam logic [7:0]  ACC_ADDR = 8'hA5;
    // Control word: address, auto precharge, bank, access, termination
    localparam logic [15:0] ACC_CMD  = {ACC_ADDR, 1'h1, ACC_BANK, 2'h3, 2'h0};
    logic        mclk      = 1'b0;
    logic        srst      = 1'b1;
    logic [1:0]  reg_addr  = 2'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [15:0] reg_rdata;
    logic [15:0] rd_val;
    logic [13:0] mode_reg, emr1_reg, act_row_reg, col_reg;
    logic [2:0]  act_bank_reg;
    logic        mode_valid_reg, dll_on_reg, dll_locked_reg, self_ref_reg, odt_active_reg, auto_pre_reg;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    always #50 mclk = ~mclk;
    dim_link_if lnk ();
    dim_ctrl #(.PWR_WAIT_CYC(PWR)) u_dim_ctrl (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk(lnk));
    dim_dram u_dim_dram (.lnk(lnk), .mclk(mclk), .srst(srst), .mode_reg(mode_reg), .emr1_reg(emr1_reg),
        .mode_valid_reg(mode_valid_reg), .dll_on_reg(dll_on_reg), .dll_locked_reg(dll_locked_reg),
        .self_ref_reg(self_ref_reg), .odt_active_reg(odt_active_reg), .act_bank_reg(act_bank_reg),
        .act_row_reg(act_row_reg), .col_reg(col_reg), .auto_pre_reg(auto_pre_reg));
    dim_link_props #(.PWR_WAIT(PWR)) u_dim_link_props (.mclk(mclk), .srst(srst), .cke(lnk.cke),
        .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n), .ba(lnk.ba),
        .addr(lnk.addr), .odt(lnk.odt));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        reg_read(2'h3);
        while (rd_val[b] !== v && n < 3000) begin
            reg_read(2'h3);
            n++;
        end
        check({15'h0000, rd_val[b]}, {15'h0000, v}, "status bit");
    endtask
    task automatic t_init();
        reg_write(2'h1, {2'b00, MR_A});
        reg_write(2'h2, {2'b00, EMR1_A});
        reg_read(2'h1);
        check({2'b00, rd_val[13:0]}, {2'b00, MR_A}, "mode image readback");
        reg_write(2'h0, 16'h0001);
        wait_stat(4, 1'b1);
        check({2'b00, mode_reg}, {2'b00, MR_A}, "mode register");
        check({2'b00, emr1_reg}, {2'b00, EMR1_A}, "extended register one");
        check({15'h0000, mode_valid_reg}, 16'h0001, "mode written");
        check({15'h0000, dll_on_reg}, 16'h0001, "DLL on");
        wait_stat(5, 1'b1);
        check({15'h0000, dll_locked_reg}, 16'h0001, "DLL locked");
    endtask
    // One activate and one read with auto precharge, termination on meanwhile
    task automatic t_access();
        reg_write(2'h0, ACC_CMD);
        repeat (12) @(posedge mclk);
        #1;
        check({13'h0000, act_bank_reg}, {13'h0000, ACC_BANK}, "activated bank");
        check({2'h0, act_row_reg}, {8'h00, ACC_ADDR}, "activated row");
        check({2'h0, col_reg}, {5'h00, 1'h1, 2'h0, ACC_ADDR}, "read column");
        check({15'h0000, auto_pre_reg}, 16'h0001, "auto precharge");
        check({15'h0000, odt_active_reg}, 16'h0001, "termination active");
        reg_write(2'h0, 16'h0000);
    endtask
    // Reinit with a full new image; other register must survive
    task automatic t_reinit();
        reg_write(2'h1, {2'b00, MR_B});
        reg_write(2'h0, 16'h0001);
        wait_stat(4, 1'b0);
        wait_stat(4, 1'b1);
        check({2'b00, mode_reg}, {2'b00, MR_B}, "mode register rewritten");
        check({2'b00, emr1_reg}, {2'b00, EMR1_A}, "extended register kept");
    endtask
    task automatic t_selfref();
        int n;
        n = 0;
        reg_write(2'h0, 16'h0002);
        while (self_ref_reg !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        #1;
        check({15'h0000, self_ref_reg}, 16'h0001, "self refresh entered");
        check({15'h0000, dll_on_reg}, 16'h0000, "DLL off in self refresh");
        check({15'h0000, dll_locked_reg}, 16'h0000, "lock lost in self refresh");
        check({15'h0000, lnk.cke}, 16'h0000, "clock enable low");
        reg_write(2'h0, 16'h0000);
        n = 0;
        while (dll_locked_reg !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        #1;
        check({15'h0000, self_ref_reg}, 16'h0000, "self refresh left");
        check({15'h0000, dll_on_reg}, 16'h0001, "DLL back on");
        check({15'h0000, n >= 200}, 16'h0001, "relock wait");
    endtask
    // Termination switched off in the image: the pin is then ignored
    task automatic t_odt_off();
        wait_stat(4, 1'b1);
        reg_write(2'h2, {2'h0, EMR1_B});
        reg_write(2'h0, 16'h0001);
        wait_stat(4, 1'b0);
        wait_stat(4, 1'b1);
        reg_write(2'h0, 16'h0004);
        repeat (4) @(posedge mclk);
        #1;
        check({2'h0, emr1_reg}, {2'h0, EMR1_B}, "termination disabled image");
        check({15'h0000, lnk.odt}, 16'h0001, "termination pin high");
        check({15'h0000, odt_active_reg}, 16'h0000, "termination ignored");
    endtask
    // Ceiling well above three init runs and a relock
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("BAD %0t run did not finish", $time);
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_init();
        t_access();
        t_reinit();
        t_selfref();
        t_odt_off();
        report_and_stop();
    end
endmodule // test_ddr2_init_mode_register
